/* supervisor_pkg.sv */
// Shared constants and carrier types for the supply supervisor core
package supervisor_pkg;

    // Timebase tick period assumed for the default tick counts
    localparam int TICK_PERIOD_US = 1000;

    // Reset stretch durations
    localparam int STRETCH_STD_MS  = 50;
    localparam int STRETCH_LONG_MS = 200;

    // Watchdog timeouts
    localparam int WD_FAST_MS = 100;
    localparam int WD_SLOW_MS = 1600;

    // Derived tick counts, one tick per millisecond by default
    localparam int STRETCH_STD_TICKS  = STRETCH_STD_MS * 1000 / TICK_PERIOD_US;
    localparam int STRETCH_LONG_TICKS = STRETCH_LONG_MS * 1000 / TICK_PERIOD_US;
    localparam int WD_FAST_TICKS      = WD_FAST_MS * 1000 / TICK_PERIOD_US;
    localparam int WD_SLOW_TICKS      = WD_SLOW_MS * 1000 / TICK_PERIOD_US;

    localparam int CNT_W = 16;

    // Service input levels
    typedef enum logic [1:0] {
        SVC_LOW  = 2'h0,
        SVC_HIGH = 2'h1,
        SVC_MID  = 2'h2
    } svc_level_t;

    // Digital indications standing in for the analog comparators
    typedef struct packed {
        logic supplyLow;
        logic monitorBelow;
        logic mainBelowBackup;
        logic onBackup;
    } supply_ind_t;

    // Registered pin outputs
    typedef struct packed {
        logic resetN;
        logic supplyLowN;
        logic watchdogExpiredN;
        logic powerFailN;
        logic backupActive;
        logic chipEnableOutN;
    } sup_out_t;

    localparam sup_out_t OUT_RESET = '{
        resetN: 1'b0, supplyLowN: 1'b0, watchdogExpiredN: 1'b1,
        powerFailN: 1'b0, backupActive: 1'b0, chipEnableOutN: 1'b1
    };

endpackage

/* watchdog_timer.sv */
// Watchdog timeout counter with service-edge restart
module watchdog_timer (
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    input  wire logic                           tick,
    input  wire logic                           clear,
    input  wire supervisor_pkg::svc_level_t     level,
    input  wire logic                           fastSel,
    input  wire logic [supervisor_pkg::CNT_W-1:0] fastTicks,
    input  wire logic [supervisor_pkg::CNT_W-1:0] slowTicks,
    output logic                                expire,
    output logic                                serviceEdge
);

    logic [supervisor_pkg::CNT_W-1:0] cnt_r;
    logic [supervisor_pkg::CNT_W-1:0] cnt_nxt;
    supervisor_pkg::svc_level_t       last_r;
    supervisor_pkg::svc_level_t       last_nxt;
    logic                             afterReset_r;
    logic                             afterReset_nxt;
    logic [supervisor_pkg::CNT_W-1:0] limit;
    logic                             enabled;

    always_comb begin
        enabled = (level != supervisor_pkg::SVC_MID);
        serviceEdge = enabled && (last_r != supervisor_pkg::SVC_MID)
                      && (level != last_r);
        limit = (fastSel && !afterReset_r) ? fastTicks : slowTicks;
        last_nxt = level;
        cnt_nxt = cnt_r;
        afterReset_nxt = afterReset_r;
        expire = 1'b0;
        if (clear) begin
            cnt_nxt = '0;
            afterReset_nxt = 1'b1;
        end else if (!enabled || serviceEdge) begin
            cnt_nxt = '0;
            if (serviceEdge) begin
                afterReset_nxt = 1'b0;
            end
        end else if (tick) begin
            if (cnt_r + 1'b1 >= limit) begin
                expire = 1'b1;
                cnt_nxt = '0;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            last_r <= supervisor_pkg::SVC_MID;
            afterReset_r <= 1'b1;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            last_r <= last_nxt;
            afterReset_r <= afterReset_nxt;
        end
    end

endmodule

/* supply_supervisor_watchdog.sv */
// Supply supervisor core: reset stretch, watchdog, status and CE gating
// Behaviour
// - Reset low on supply low or timeout
// - Hold reset after supply recovers
// - Watchdog timeout gives one reset pulse
// - Steady service level times out, drops status
// - Any service transition restarts timeout
// - Middle service level disables watchdog
// - Power-fail low when monitor below threshold
// - Power-fail low when main below backup
// - Chip enable gated high on supply low
// - Backup-active follows supply source
// - Supply-low output follows supply, unstretched
// - Status returns high on next low/high transition
// - Status forced high while supply low
// - Timebase pin picks fast/slow timeout when internal timebase is selected
// - Slow timeout right after any reset
module supply_supervisor_watchdog #(
    parameter logic LONG_PULSE = 1'b0,
    parameter logic [supervisor_pkg::CNT_W-1:0] STRETCH_STD =
        supervisor_pkg::CNT_W'(supervisor_pkg::STRETCH_STD_TICKS),
    parameter logic [supervisor_pkg::CNT_W-1:0] STRETCH_LONG =
        supervisor_pkg::CNT_W'(supervisor_pkg::STRETCH_LONG_TICKS),
    parameter logic [supervisor_pkg::CNT_W-1:0] WD_FAST =
        supervisor_pkg::CNT_W'(supervisor_pkg::WD_FAST_TICKS),
    parameter logic [supervisor_pkg::CNT_W-1:0] WD_SLOW =
        supervisor_pkg::CNT_W'(supervisor_pkg::WD_SLOW_TICKS)
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    input  wire logic                        timebaseTick,
    input  wire logic                        timebase_select,
    input  wire logic                        timebase_in,
    input  wire supervisor_pkg::svc_level_t  watchdog_service_in,
    input  wire supervisor_pkg::supply_ind_t supply,
    input  wire logic                        chipEnableIn_n,
    output supervisor_pkg::sup_out_t         pins
);

    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN     = 2'b10,
        ST_PULSE   = 2'b11
    } rst_state_t;

    rst_state_t                       state_r;
    rst_state_t                       state_nxt;
    logic [supervisor_pkg::CNT_W-1:0] cnt_r;
    logic [supervisor_pkg::CNT_W-1:0] cnt_nxt;
    supervisor_pkg::sup_out_t         out_r;
    supervisor_pkg::sup_out_t         out_nxt;
    logic [supervisor_pkg::CNT_W-1:0] stretchLen;
    logic                             wdExpire;
    logic                             wdEdge;
    logic                             wdClear;
    logic                             internalBase;
    logic                             tick;

    // Counts one tick; returns true when the length is reached
    function automatic logic reached(
        input logic [supervisor_pkg::CNT_W-1:0] c,
        input logic [supervisor_pkg::CNT_W-1:0] len
    );
        reached = (c + 1'b1) >= len;
    endfunction

    // High select means the internal timebase; the pin then picks the
    // watchdog speed. Otherwise the tick input is the external timebase.
    assign internalBase = timebase_select;
    assign tick = timebaseTick;
    assign stretchLen = LONG_PULSE ? STRETCH_LONG : STRETCH_STD;

    // Restart the watchdog whenever reset is asserted, so every reset
    // is followed by the slow first timeout.
    assign wdClear = (state_r != ST_RUN);

    watchdog_timer u_wd (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .tick        (tick),
        .clear       (wdClear),
        .level       (watchdog_service_in),
        .fastSel     (internalBase && timebase_in),
        .fastTicks   (WD_FAST),
        .slowTicks   (WD_SLOW),
        .expire      (wdExpire),
        .serviceEdge (wdEdge)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_HOLD: begin
                cnt_nxt = '0;
                if (!supply.supplyLow) begin
                    state_nxt = ST_STRETCH;
                end
            end
            ST_STRETCH, ST_PULSE: begin
                if (supply.supplyLow) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt = '0;
                end else if (tick) begin
                    if (reached(cnt_r, stretchLen)) begin
                        state_nxt = ST_RUN;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                cnt_nxt = '0;
                if (supply.supplyLow) begin
                    state_nxt = ST_HOLD;
                end else if (wdExpire) begin
                    state_nxt = ST_PULSE;
                end
            end
            default: begin
                state_nxt = ST_HOLD;
                cnt_nxt = '0;
            end
        endcase
    end

    always_comb begin
        out_nxt = out_r;
        out_nxt.resetN = (state_nxt == ST_RUN);
        out_nxt.supplyLowN = !supply.supplyLow;
        if (supply.supplyLow) begin
            out_nxt.watchdogExpiredN = 1'b1;
        end else if (wdExpire && state_r == ST_RUN) begin
            out_nxt.watchdogExpiredN = 1'b0;
        end else if (wdEdge) begin
            out_nxt.watchdogExpiredN = 1'b1;
        end
        out_nxt.powerFailN = !(supply.monitorBelow
                               || supply.mainBelowBackup);
        out_nxt.backupActive = supply.onBackup;
        out_nxt.chipEnableOutN = supply.supplyLow ? 1'b1 : chipEnableIn_n;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_HOLD;
            cnt_r <= '0;
            out_r <= supervisor_pkg::OUT_RESET;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign pins = out_r;

endmodule

/* supervisor_chk.sv */
// Pin-level checker for the supply supervisor core
module supervisor_chk (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        ce,
    input wire logic                        timebaseTick,
    input wire logic                        timebase_select,
    input wire logic                        timebase_in,
    input wire supervisor_pkg::svc_level_t  watchdog_service_in,
    input wire supervisor_pkg::supply_ind_t supply,
    input wire logic                        chipEnableIn_n,
    input wire supervisor_pkg::sup_out_t    pins
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Outputs only carry live values from the second edge after reset
    logic live_r;
    always_ff @(posedge mclk) live_r <= rst_n && ce;
    sequence s_recover;
        $fell(supply.supplyLow);
    endsequence
    sequence s_edge;
        live_r && watchdog_service_in != $past(watchdog_service_in) &&
        watchdog_service_in != supervisor_pkg::SVC_MID &&
        $past(watchdog_service_in) != supervisor_pkg::SVC_MID;
    endsequence
    property p_lowLine;
        live_r |-> pins.supplyLowN == !$past(supply.supplyLow);
    endproperty
    a_lowLine: assert property (p_lowLine) else $error("supply-low pin");
    property p_pf;
        live_r |-> pins.powerFailN ==
            !($past(supply.monitorBelow) || $past(supply.mainBelowBackup));
    endproperty
    a_pf: assert property (p_pf) else $error("power-fail pin");
    property p_ce;
        live_r |-> pins.chipEnableOutN ==
            ($past(supply.supplyLow) || $past(chipEnableIn_n));
    endproperty
    a_ce: assert property (p_ce) else $error("chip enable pin");
    property p_batt;
        live_r |-> pins.backupActive == $past(supply.onBackup);
    endproperty
    a_batt: assert property (p_batt) else $error("backup pin");
    property p_hold;
        s_recover |-> !pins.resetN [*4];
    endproperty
    a_hold: assert property (p_hold) else $error("reset stretch");
    property p_pulse;
        $fell(pins.watchdogExpiredN) |-> !pins.resetN [*4];
    endproperty
    a_pulse: assert property (p_pulse) else $error("timeout pulse");
    property p_edge;
        s_edge |=> pins.watchdogExpiredN;
    endproperty
    a_edge: assert property (p_edge) else $error("status clear");
    property p_mid;
        (watchdog_service_in == supervisor_pkg::SVC_MID) [*2]
            |-> !$fell(pins.watchdogExpiredN);
    endproperty
    a_mid: assert property (p_mid) else $error("mid level expiry");
    property p_lowStatus;
        ce && supply.supplyLow |=> pins.watchdogExpiredN;
    endproperty
    a_lowStatus: assert property (p_lowStatus) else $error("status low");
endmodule
bind supply_supervisor_watchdog supervisor_chk u_chk (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .timebaseTick(timebaseTick),
    .timebase_select(timebase_select), .timebase_in(timebase_in),
    .watchdog_service_in(watchdog_service_in), .supply(supply),
    .chipEnableIn_n(chipEnableIn_n), .pins(pins)
);

/* host_model.sv */
// Host model driving the three-level watchdog service line
module host_model (
    input  wire logic                  mclk,
    input  wire logic                  tick,
    input  wire logic [1:0]            mode,
    output supervisor_pkg::svc_level_t svc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial svc = supervisor_pkg::SVC_MID;
    // Mode 0 parks mid
    // Moves just after a tick so no tick shares an edge with a transition
    always @(posedge mclk) begin
        if (tick) begin
            case (mode)
                2'h0: svc <= supervisor_pkg::SVC_MID;
                2'h1: svc <= supervisor_pkg::SVC_HIGH;
                2'h2: svc <= supervisor_pkg::SVC_LOW;
                default: svc <= (svc == supervisor_pkg::SVC_HIGH) ?
                    supervisor_pkg::SVC_LOW : supervisor_pkg::SVC_HIGH;
            endcase
        end
    end
endmodule

/* supply_supervisor_watchdog_tb.sv */
// Self-checking bench for the supply supervisor core
module supply_supervisor_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] N_STR  = 16'h0003;
    localparam logic [15:0] N_FAST = 16'h0004;
    localparam logic [15:0] N_SLOW = 16'h0008;
    logic                        mclk, rst_n, ce, timebaseTick;
    logic                        timebase_select, timebase_in, chipEnableIn_n;
    logic [1:0]                  mode;
    logic [15:0]                 seed, cyc, lowTicks, highTicks;
    int                          error_cnt, checked;
    supervisor_pkg::svc_level_t  svc, svcPrev;
    supervisor_pkg::supply_ind_t supply;
    supervisor_pkg::sup_out_t    pins;
    supply_supervisor_watchdog #(
        .LONG_PULSE(1'b0), .STRETCH_STD(N_STR), .STRETCH_LONG(16'h0005),
        .WD_FAST(N_FAST), .WD_SLOW(N_SLOW)
    ) dut (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .timebaseTick(timebaseTick),
        .timebase_select(timebase_select), .timebase_in(timebase_in),
        .watchdog_service_in(svc), .supply(supply),
        .chipEnableIn_n(chipEnableIn_n), .pins(pins)
    );
    host_model host (.mclk(mclk), .tick(timebaseTick), .mode(mode), .svc(svc));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string what, input logic [15:0] exp, got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic waitPin(input int b, input logic v);
        int n;
        n = 0;
        while (pins[b] !== v && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        chk("pin wait", {15'h0, v}, {15'h0, pins[b]});
    endtask
    task automatic final_report();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Sparse ticks keep transitions and release edges off tick edges
    always @(posedge mclk) begin
        cyc <= cyc + 16'h1;
        timebaseTick <= (cyc[1:0] == 2'h3);
        svcPrev <= svc;
        if (svc != svcPrev || !pins.resetN) highTicks <= 16'h0;
        else if (timebaseTick) highTicks <= highTicks + 16'h1;
        if (timebaseTick && !pins.resetN && pins.supplyLowN)
            lowTicks <= lowTicks + 16'h1;
    end
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    initial begin
        {rst_n, timebaseTick, mode, cyc, lowTicks, highTicks} = '0;
        {ce, timebase_select, timebase_in, chipEnableIn_n} = 4'hf;
        {error_cnt, checked} = '0;
        seed = 16'h001f;
        svcPrev = supervisor_pkg::SVC_MID;
        supply = supervisor_pkg::supply_ind_t'(4'h8);
        repeat (10) @(posedge mclk);
        #1 chk("reset pins", {10'h0, supervisor_pkg::OUT_RESET}, {10'h0, pins});
        @(posedge mclk);
        rst_n <= 1'b1;
        mode <= 2'h1;
        repeat (3) @(posedge mclk);
        supply.supplyLow <= 1'b0;
        @(negedge mclk) lowTicks = 16'h0;
        waitPin(5, 1'b1);
        chk("stretch ticks", N_STR, lowTicks);
        waitPin(3, 1'b0);
        chk("first timeout", N_SLOW, highTicks);
        chk("pulse low", 16'h0, {15'h0, pins.resetN});
        lowTicks = 16'h0;
        waitPin(5, 1'b1);
        chk("pulse ticks", N_STR, lowTicks);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            timebase_select <= (i != 2);
            timebase_in <= (i == 0);
            mode <= 2'h3;
            repeat (40) @(negedge mclk);
            chk("status back", 16'h1, {15'h0, pins.watchdogExpiredN});
            chk("served reset", 16'h1, {15'h0, pins.resetN});
            @(posedge mclk);
            mode <= (i == 1) ? 2'h2 : 2'h1;
            waitPin(3, 1'b0);
            chk("timeout ticks", (i == 0) ? N_FAST : N_SLOW, highTicks);
            waitPin(5, 1'b1);
        end
        @(posedge mclk);
        mode <= 2'h3;
        repeat (12) @(posedge mclk);
        mode <= 2'h0;
        repeat (100) @(negedge mclk);
        chk("mid reset", 16'h1, {15'h0, pins.resetN});
        // Clock enable low must freeze the gated chip-enable pin
        @(posedge mclk);
        ce <= 1'b0;
        chipEnableIn_n <= 1'b0;
        repeat (5) @(negedge mclk);
        chk("frozen ce", 16'h1, {15'h0, pins.chipEnableOutN});
        @(posedge mclk);
        ce <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("ce out", 16'h0, {15'h0, pins.chipEnableOutN});
        repeat (2000) begin
            @(posedge mclk);
            seed = lfsr(seed);
            supply <= supervisor_pkg::supply_ind_t'({seed[11:4] == 8'h0,
                seed[2:0]});
            chipEnableIn_n <= seed[3];
            mode <= seed[13:12];
        end
        final_report();
    end
endmodule
